// [rtl/tcc_pkg.sv]
// Purpose: constants and types of the timer/counter block with capture
// Assumes: APB slave, 32-bit data, one word per register, pclk 100 MHz

package tcc_pkg;

  // register byte addresses
  localparam logic [7:0] TCC_ADDR_SPEED = 8'h00;
  localparam logic [7:0] TCC_ADDR_MODE = 8'h04;
  localparam logic [7:0] TCC_ADDR_CTRL = 8'h08;
  localparam logic [7:0] TCC_ADDR_T0LO = 8'h0C;
  localparam logic [7:0] TCC_ADDR_T0HI = 8'h10;
  localparam logic [7:0] TCC_ADDR_T1LO = 8'h14;
  localparam logic [7:0] TCC_ADDR_T1HI = 8'h18;
  localparam logic [7:0] TCC_ADDR_T2CTL = 8'h1C;
  localparam logic [7:0] TCC_ADDR_T2LO = 8'h20;
  localparam logic [7:0] TCC_ADDR_T2HI = 8'h24;
  localparam logic [7:0] TCC_ADDR_CAPLO = 8'h28;
  localparam logic [7:0] TCC_ADDR_CAPHI = 8'h2C;
  localparam logic [7:0] TCC_ADDR_STAT = 8'h30;
  localparam logic [7:0] TCC_ADDR_MASK = 8'h34;

  // speed register fields
  localparam int TCC_SPD_ZERO = 0;
  localparam int TCC_SPD_ONE = 1;
  localparam int TCC_SPD_TWO = 2;
  // mode register fields
  localparam int TCC_MD_M0_LSB = 0;
  localparam int TCC_MD_CT0 = 2;
  localparam int TCC_MD_GATE0 = 3;
  localparam int TCC_MD_M1_LSB = 4;
  localparam int TCC_MD_CT1 = 6;
  localparam int TCC_MD_GATE1 = 7;
  // control register fields
  localparam int TCC_CT_RUN0 = 4;
  localparam int TCC_CT_OVF0 = 5;
  localparam int TCC_CT_RUN1 = 6;
  localparam int TCC_CT_OVF1 = 7;
  // third timer control fields
  localparam int TCC_T2_CAPSEL = 0;
  localparam int TCC_T2_SRC = 1;
  localparam int TCC_T2_RUN = 2;
  localparam int TCC_T2_EXTEN = 3;
  // status and mask fields
  localparam int TCC_ST_OVF0 = 0;
  localparam int TCC_ST_OVF1 = 1;
  localparam int TCC_ST_OVF2 = 2;
  localparam int TCC_ST_EXT = 3;

  // reset values
  localparam logic [7:0] TCC_RST_BYTE = 8'h00;
  localparam logic [3:0] TCC_RST_NIB = 4'h0;

  // time base dividers, in pclk cycles per tick
  localparam int TCC_DIV_SLOW = 12;
  localparam int TCC_DIV_FAST = 6;

  typedef enum logic [1:0] {
    TCC_MODE13,
    TCC_MODE16,
    TCC_RELOAD8,
    TCC_SPLIT
  } tcc_mode_t;

  // one count step result
  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } tcc_cnt_t;

  // synchronised external pins
  typedef struct packed {
    logic cnt0;
    logic cnt1;
    logic cnt2;
    logic trig;
    logic gate0;
    logic gate1;
  } tcc_pins_t;

endpackage

// [rtl/tcc_timers.sv]
// Purpose: two mode 0-3 timer/counters and a third with capture, on APB
// Assumes: pins asynchronous to pclk, two-flop synchronised; zero-wait APB, full-word writes
// Notes: all outputs come from flip-flops

`timescale 1ns/100ps
`default_nettype none

module tcc_timers
  import tcc_pkg::*;
#(
  parameter int DIV_SLOW = TCC_DIV_SLOW,
  parameter int DIV_FAST = TCC_DIV_FAST
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // external pins
  input wire logic first_timer_count_pin,
  input wire logic second_timer_count_pin,
  input wire logic third_timer_count_pin,
  input wire logic external_trigger_pin,
  input wire logic first_gating_interrupt_pin,
  input wire logic second_gating_interrupt_pin,
  // option strap: high selects twelve clocks per machine cycle
  input wire logic twelve_clock_option
);

  // the four-bit prescaler cannot count past sixteen
  if (DIV_FAST < 1 || DIV_SLOW != 2 * DIV_FAST || DIV_SLOW > 16)
  begin
    $error("tcc_timers: dividers must satisfy slow = 2 * fast <= 16");
  end

  localparam logic [3:0] SLOW_LAST = 4'(DIV_SLOW - 1);
  localparam logic [3:0] FAST_LAST = 4'(DIV_FAST - 1);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // picks the tick for one timer; the strap overrides turbo
  function automatic logic pick_tick(input logic turbo, input logic opt12,
                                     input logic tslow, input logic tfast);
    pick_tick = (turbo && !opt12) ? tfast : tslow;
  endfunction

  // one step of a timer in modes 0 to 2; mode 3 holds the value
  function automatic tcc_cnt_t cnt_step(input tcc_mode_t md,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input logic inc);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'd1;
    s16 = {1'b0, hi, lo} + 17'd1;
    s8 = {1'b0, lo} + 9'd1;
    cnt_step = '{ovf: 1'b0, hi: hi, lo: lo};
    if (inc)
    begin
      unique case (md)
        TCC_MODE13:
        begin
          // upper three low-byte bits are left alone
          cnt_step = '{ovf: s13[13], hi: s13[12:5],
                       lo: {lo[7:5], s13[4:0]}};
        end
        TCC_MODE16:
        begin
          cnt_step = '{ovf: s16[16], hi: s16[15:8],
                       lo: s16[7:0]};
        end
        TCC_RELOAD8:
        begin
          cnt_step = '{ovf: s8[8], hi: hi,
                       lo: s8[8] ? hi : s8[7:0]};
        end
        TCC_SPLIT:
        begin
          cnt_step = '{ovf: 1'b0, hi: hi, lo: lo};
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0] speed_ff;
  logic [7:0] mode_ff;
  logic run0_ff;
  logic run1_ff;
  logic [3:0] t2ctl_ff;
  logic [7:0] t0lo_ff;
  logic [7:0] t0hi_ff;
  logic [7:0] t1lo_ff;
  logic [7:0] t1hi_ff;
  logic [7:0] t2lo_ff;
  logic [7:0] t2hi_ff;
  logic [7:0] caplo_ff;
  logic [7:0] caphi_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [3:0] presc_ff;
  logic opt12_ff;
  tcc_pins_t sync1_ff;
  tcc_pins_t sync2_ff;
  tcc_pins_t prev_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite && pready_ff;
  wire logic wr_speed = wr_en && (paddr == TCC_ADDR_SPEED);
  wire logic wr_mode = wr_en && (paddr == TCC_ADDR_MODE);
  wire logic wr_ctrl = wr_en && (paddr == TCC_ADDR_CTRL);
  wire logic wr_t0lo = wr_en && (paddr == TCC_ADDR_T0LO);
  wire logic wr_t0hi = wr_en && (paddr == TCC_ADDR_T0HI);
  wire logic wr_t1lo = wr_en && (paddr == TCC_ADDR_T1LO);
  wire logic wr_t1hi = wr_en && (paddr == TCC_ADDR_T1HI);
  wire logic wr_t2ctl = wr_en && (paddr == TCC_ADDR_T2CTL);
  wire logic wr_t2lo = wr_en && (paddr == TCC_ADDR_T2LO);
  wire logic wr_t2hi = wr_en && (paddr == TCC_ADDR_T2HI);
  wire logic wr_stat = wr_en && (paddr == TCC_ADDR_STAT);
  wire logic wr_mask = wr_en && (paddr == TCC_ADDR_MASK);

  wire logic [7:0] ctrl_rd = {status_ff[TCC_ST_OVF1], run1_ff,
                              status_ff[TCC_ST_OVF0], run0_ff, 4'h0};

  // capture bytes are read-only; writes there are ignored
  wire logic addr_ok = (paddr[1:0] == 2'b00) && (paddr <= TCC_ADDR_MASK);
  wire logic [7:0] rd_byte =
    (paddr == TCC_ADDR_SPEED) ? {5'h00, speed_ff} :
    (paddr == TCC_ADDR_MODE) ? mode_ff :
    (paddr == TCC_ADDR_CTRL) ? ctrl_rd :
    (paddr == TCC_ADDR_T0LO) ? t0lo_ff :
    (paddr == TCC_ADDR_T0HI) ? t0hi_ff :
    (paddr == TCC_ADDR_T1LO) ? t1lo_ff :
    (paddr == TCC_ADDR_T1HI) ? t1hi_ff :
    (paddr == TCC_ADDR_T2CTL) ? {4'h0, t2ctl_ff} :
    (paddr == TCC_ADDR_T2LO) ? t2lo_ff :
    (paddr == TCC_ADDR_T2HI) ? t2hi_ff :
    (paddr == TCC_ADDR_CAPLO) ? caplo_ff :
    (paddr == TCC_ADDR_CAPHI) ? caphi_ff :
    (paddr == TCC_ADDR_STAT) ? {4'h0, status_ff} :
    (paddr == TCC_ADDR_MASK) ? {4'h0, mask_ff} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // time base and pin edges

  // one shared prescaler keeps the three timers' ticks in step
  wire logic tick_slow = (presc_ff == SLOW_LAST);
  wire logic tick_fast = tick_slow || (presc_ff == FAST_LAST);
  wire logic [3:0] nxt_presc = tick_slow ? 4'h0 : presc_ff + 4'h1;

  wire logic tick0 = pick_tick(speed_ff[TCC_SPD_ZERO], opt12_ff,
                               tick_slow, tick_fast);
  wire logic tick1 = pick_tick(speed_ff[TCC_SPD_ONE], opt12_ff,
                               tick_slow, tick_fast);
  wire logic tick2 = pick_tick(speed_ff[TCC_SPD_TWO], opt12_ff,
                               tick_slow, tick_fast);

  wire tcc_pins_t pins_in = '{cnt0: first_timer_count_pin,
                              cnt1: second_timer_count_pin,
                              cnt2: third_timer_count_pin,
                              trig: external_trigger_pin,
                              gate0: first_gating_interrupt_pin,
                              gate1: second_gating_interrupt_pin};
  // a fall is one sample high then one low, so at most one edge per two samples
  wire tcc_pins_t fall = prev_ff & ~sync2_ff;

  ////////////////////////////////////////////////////////////////////////
  // first and second timers

  wire tcc_mode_t md0 = tcc_mode_t'(mode_ff[TCC_MD_M0_LSB +: 2]);
  wire tcc_mode_t md1 = tcc_mode_t'(mode_ff[TCC_MD_M1_LSB +: 2]);
  wire logic split = (md0 == TCC_SPLIT);

  wire logic en0 = run0_ff &&
                   (!mode_ff[TCC_MD_GATE0] || sync2_ff.gate0);
  wire logic inc0 = en0 &&
                    (mode_ff[TCC_MD_CT0] ? fall.cnt0 : tick0);
  wire tcc_cnt_t st0 = cnt_step(md0, t0hi_ff, t0lo_ff, inc0);

  // split mode: two free 8-bit counters
  wire logic [8:0] sp_lo = {1'b0, t0lo_ff} + {8'h00, inc0};
  wire logic inc0h = run1_ff && tick0;
  wire logic [8:0] sp_hi = {1'b0, t0hi_ff} + {8'h00, inc0h};

  // with the first timer split, the second runs without its run bit
  wire logic en1 = (split || run1_ff) &&
                   (!mode_ff[TCC_MD_GATE1] || sync2_ff.gate1);
  wire logic inc1 = en1 &&
                    (mode_ff[TCC_MD_CT1] ? fall.cnt1 : tick1);
  // mode 3 on the second timer returns the count unchanged
  wire tcc_cnt_t st1 = cnt_step(md1, t1hi_ff, t1lo_ff, inc1);

  wire logic ev_ovf0 = split ? sp_lo[8] : st0.ovf;
  // second timer overflow is lost while the first is split
  wire logic ev_ovf1 = split ? sp_hi[8] : st1.ovf;

  // writes win over a count in the same cycle
  wire logic [7:0] nxt_t0lo = wr_t0lo ? pwdata[7:0] :
                              split ? sp_lo[7:0] : st0.lo;
  wire logic [7:0] nxt_t0hi = wr_t0hi ? pwdata[7:0] :
                              split ? sp_hi[7:0] : st0.hi;
  wire logic [7:0] nxt_t1lo = wr_t1lo ? pwdata[7:0] : st1.lo;
  wire logic [7:0] nxt_t1hi = wr_t1hi ? pwdata[7:0] : st1.hi;

  ////////////////////////////////////////////////////////////////////////
  // third timer

  wire logic inc2 = t2ctl_ff[TCC_T2_RUN] &&
                    (t2ctl_ff[TCC_T2_SRC] ? fall.cnt2 : tick2);
  wire logic [16:0] s2 = {1'b0, t2hi_ff, t2lo_ff} + {16'h0000, inc2};
  wire logic ev_ovf2 = s2[16];
  // capture takes the count as it stands before this cycle's step
  wire logic ev_cap = t2ctl_ff[TCC_T2_CAPSEL] &&
                      t2ctl_ff[TCC_T2_EXTEN] && fall.trig;
  wire logic [7:0] nxt_t2lo = wr_t2lo ? pwdata[7:0] : s2[7:0];
  wire logic [7:0] nxt_t2hi = wr_t2hi ? pwdata[7:0] : s2[15:8];

  ////////////////////////////////////////////////////////////////////////
  // flags and interrupt

  wire logic [3:0] events = {ev_cap, ev_ovf2, ev_ovf1, ev_ovf0};
  wire logic [3:0] clr = wr_stat ? pwdata[3:0] : 4'h0;
  // a new event in the clearing cycle keeps its flag set
  wire logic [3:0] nxt_status = (status_ff & ~clr) | events;
  wire logic [3:0] nxt_mask = wr_mask ? pwdata[3:0] : mask_ff;

  ////////////////////////////////////////////////////////////////////////
  // flip-flops

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
      opt12_ff <= 1'b0;
      presc_ff <= 4'h0;
    end
    else
    begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      opt12_ff <= twelve_clock_option;
      presc_ff <= nxt_presc;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_ff <= 3'b000;
      mode_ff <= TCC_RST_BYTE;
      run0_ff <= 1'b0;
      run1_ff <= 1'b0;
      t2ctl_ff <= TCC_RST_NIB;
      mask_ff <= TCC_RST_NIB;
      status_ff <= TCC_RST_NIB;
    end
    else
    begin
      if (wr_speed)
        speed_ff <= pwdata[2:0];
      if (wr_mode)
        mode_ff <= pwdata[7:0];
      if (wr_ctrl)
        run0_ff <= pwdata[TCC_CT_RUN0];
      if (wr_ctrl)
        run1_ff <= pwdata[TCC_CT_RUN1];
      if (wr_t2ctl)
        t2ctl_ff <= pwdata[3:0];
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t0lo_ff <= TCC_RST_BYTE;
      t0hi_ff <= TCC_RST_BYTE;
      t1lo_ff <= TCC_RST_BYTE;
      t1hi_ff <= TCC_RST_BYTE;
      t2lo_ff <= TCC_RST_BYTE;
      t2hi_ff <= TCC_RST_BYTE;
    end
    else
    begin
      t0lo_ff <= nxt_t0lo;
      t0hi_ff <= nxt_t0hi;
      t1lo_ff <= nxt_t1lo;
      t1hi_ff <= nxt_t1hi;
      t2lo_ff <= nxt_t2lo;
      t2hi_ff <= nxt_t2hi;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      caplo_ff <= TCC_RST_BYTE;
      caphi_ff <= TCC_RST_BYTE;
    end
    else if (ev_cap)
    begin
      caplo_ff <= t2lo_ff;
      caphi_ff <= t2hi_ff;
    end
  end

  // read data is latched in the setup cycle, answer in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_ok;
    end
  end

  // irq follows the next flag value so it rises on the same edge as them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

// [bench/tcc_timers_assertions.sv]
// Purpose: port-level checks of the timer block's apb face and flags
// Assumes: one clock domain, presetn asynchronous and active low
// Notes: mirrors follow software writes; counts are left to the bench

`timescale 1ns/100ps
`default_nettype none

module tcc_timers_checker
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt
  input wire logic irq
);

  logic wr_c;
  logic rd_c;
  logic [2:0] spd_ff;
  logic [7:0] mode_ff;
  logic [1:0] run_ff;
  logic [3:0] mask_ff;
  logic [3:0] seen_ff;

  assign wr_c = psel && penable && pready && pwrite;
  assign rd_c = psel && penable && pready && !pwrite;

  // seen flags only shrink on a one written to status, so a set-wins
  // race cannot make the sticky check fire
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spd_ff <= 3'h0;
      mode_ff <= 8'h00;
      run_ff <= 2'h0;
      mask_ff <= 4'h0;
      seen_ff <= 4'h0;
    end
    else if (wr_c)
    begin
      if (paddr == TCC_ADDR_SPEED) spd_ff <= pwdata[2:0];
      if (paddr == TCC_ADDR_MODE) mode_ff <= pwdata[7:0];
      if (paddr == TCC_ADDR_CTRL) run_ff <= {pwdata[6], pwdata[4]};
      if (paddr == TCC_ADDR_MASK) mask_ff <= pwdata[3:0];
      if (paddr == TCC_ADDR_STAT) seen_ff <= seen_ff & ~pwdata[3:0];
    end
    else if (rd_c && paddr == TCC_ADDR_STAT)
      seen_ff <= prdata[3:0];
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  idle_quiet_a:
    assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside access");
  err_decode_a:
    assert property (pready |->
      pslverr == (paddr > TCC_ADDR_MASK || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address decode");
  upper_zero_a:
    assert property (rd_c |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  speed_readback_a:
    assert property (rd_c && paddr == TCC_ADDR_SPEED |->
      prdata[7:0] == {5'h00, spd_ff})
    else $error("speed register readback wrong");
  mode_readback_a:
    assert property (rd_c && paddr == TCC_ADDR_MODE |->
      prdata[7:0] == mode_ff)
    else $error("mode register readback wrong");
  run_readback_a:
    assert property (rd_c && paddr == TCC_ADDR_CTRL |->
      {prdata[6], prdata[4]} == run_ff)
    else $error("run bits readback wrong");
  flag_sticky_a:
    assert property (rd_c && paddr == TCC_ADDR_STAT |->
      (prdata[3:0] & seen_ff) == seen_ff)
    else $error("status flag dropped without clear");
  irq_masked_a:
    assert property (irq |-> (mask_ff | $past(mask_ff)) != 4'h0)
    else $error("irq high with every source masked");

endmodule

bind tcc_timers tcc_timers_checker i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq(irq)
);

`default_nettype wire

// [bench/tcc_tb.sv]
// Purpose: self-checking bench for the timer block with capture
// Assumes: bench is the apb master and drives every pin itself
// Notes: reads leave notes; a monitor compares them as answers land

`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected %s exp %0h got %0h", n, e, g); \
    end \
  end

module tb;
  import tcc_pkg::*;

  typedef struct {
    string nm;
    logic [31:0] ex;
    logic [31:0] sp;
    logic [31:0] mk;
    logic er;
    logic [1:0] iq;
  } tcc_note_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [3:0] cpin = 4'hf;
  logic [1:0] gpin = 2'h3;
  logic strap = 1'b0;
  logic [31:0] seed = 32'h0000_3048;
  int n_errors = 0;
  int check_count = 0;
  tcc_note_t notes[$];

  tcc_timers i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .first_timer_count_pin(cpin[0]), .second_timer_count_pin(cpin[1]),
    .third_timer_count_pin(cpin[2]), .external_trigger_pin(cpin[3]),
    .first_gating_interrupt_pin(gpin[0]),
    .second_gating_interrupt_pin(gpin[1]), .twelve_clock_option(strap)
  );

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_errors++;
      end_of_test();
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
    input logic [31:0] ex, input logic [31:0] sp = 0,
    input logic [31:0] mk = 32'h0000_00ff, input logic er = 1'b0,
    input logic [1:0] iq = 2'b00);
    notes.push_back('{nm, ex, sp, mk, er, iq});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // pins stay low and high three cycles so no two falls can merge
  task automatic fall(input int p, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      cpin[p] <= 1'b0;
      repeat (3) @(posedge pclk);
      cpin[p] <= 1'b1;
      repeat (2) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  always @(posedge pclk)
  begin
    tcc_note_t t;
    logic [31:0] g;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (notes.size() == 0)
        `CHK("note queue", 1'b1, 1'b0)
      else
      begin
        t = notes.pop_front();
        g = prdata & t.mk;
        if (g >= t.ex && g <= t.ex + t.sp)
          g = t.ex;
        `CHK(t.nm, t.ex, g)
        `CHK("pslverr", t.er, pslverr)
        if (t.iq[1])
          `CHK("irq", t.iq[0], irq)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int t, m, r, n, x;
    logic [7:0] lo, hi;
    do_reset();
    for (int i = 0; i < 14; i++)
      rd("reset value", 8'(i * 4), 0, 0, 32'hffff_ffff);
    rd("unmapped", 8'h38, 0, 0, 32'hffff_ffff, 1'b1);
    rd("unaligned", 8'h05, 0, 0, 32'hffff_ffff, 1'b1);
    $display("test reset done");
    wr(TCC_ADDR_MODE, 8'h11);
    wr(TCC_ADDR_CTRL, 8'h50);
    wr(TCC_ADDR_T2CTL, 8'h04);
    for (int k = 0; k < 3; k++)
    begin
      strap <= (k == 2);
      wr(TCC_ADDR_SPEED, k == 0 ? 8'h00 : 8'h07);
      wr(TCC_ADDR_T0LO, 8'h00);
      wr(TCC_ADDR_T1LO, 8'h00);
      wr(TCC_ADDR_T2LO, 8'h00);
      repeat (111) @(posedge pclk);
      rd("t0 ticks", TCC_ADDR_T0LO, k == 1 ? 18 : 8, 4);
      rd("t1 ticks", TCC_ADDR_T1LO, k == 1 ? 18 : 8, 4);
      rd("t2 ticks", TCC_ADDR_T2LO, k == 1 ? 18 : 8, 4);
    end
    $display("test time base done");
    wr(TCC_ADDR_T2CTL, 8'h00);
    for (t = 0; t < 2; t++)
      for (m = 0; m < 3; m++)
      begin
        // stop both timers so the idle one cannot raise a stray flag
        wr(TCC_ADDR_CTRL, 8'h00);
        seed = lfsr(seed);
        r = seed[1:0];
        n = r + 1 + seed[2];
        x = n - r - 1;
        hi = (m == 2) ? seed[15:8] : 8'hff;
        lo = (m == 0) ? {seed[7:5], 5'h1f - 5'(r)} : 8'hff - 8'(r);
        wr(TCC_ADDR_MODE, 32'(4 + m) << (4 * t));
        wr(TCC_ADDR_MASK, t == 0 ? 8'h01 : 8'h00);
        wr(t ? TCC_ADDR_T1HI : TCC_ADDR_T0HI, hi);
        wr(t ? TCC_ADDR_T1LO : TCC_ADDR_T0LO, lo);
        wr(TCC_ADDR_CTRL, t ? 8'h40 : 8'h10);
        fall(t, n);
        rd("overflow", TCC_ADDR_STAT, 1 << t, 0, 32'hf, 0,
          {1'b1, t == 0});
        wr(TCC_ADDR_STAT, 8'h0f);
        rd("cleared", TCC_ADDR_STAT, 0, 0, 32'hf, 0, 2'b10);
        rd("low", t ? TCC_ADDR_T1LO : TCC_ADDR_T0LO,
          m == 2 ? (hi + x) & 8'hff : x, 0, m == 0 ? 32'h1f : 32'hff);
        rd("high", t ? TCC_ADDR_T1HI : TCC_ADDR_T0HI,
          m == 2 ? hi : 8'h00);
      end
    $display("test modes done");
    wr(TCC_ADDR_MODE, 8'h0d);
    wr(TCC_ADDR_T0LO, 8'h10);
    gpin[0] <= 1'b0;
    wr(TCC_ADDR_CTRL, 8'h10);
    fall(0, 2);
    rd("gated", TCC_ADDR_T0LO, 8'h10);
    gpin[0] <= 1'b1;
    fall(0, 2);
    rd("gate open", TCC_ADDR_T0LO, 8'h12);
    wr(TCC_ADDR_CTRL, 8'h00);
    fall(0, 2);
    rd("stopped", TCC_ADDR_T0LO, 8'h12);
    $display("test gating done");
    wr(TCC_ADDR_SPEED, 8'h00);
    wr(TCC_ADDR_MODE, 8'h17);
    wr(TCC_ADDR_T0HI, 8'hff);
    wr(TCC_ADDR_T1HI, 8'hff);
    wr(TCC_ADDR_T1LO, 8'hff);
    wr(TCC_ADDR_T0LO, 8'hfe);
    wr(TCC_ADDR_STAT, 8'h0f);
    wr(TCC_ADDR_CTRL, 8'h10);
    fall(0, 2);
    rd("split flags", TCC_ADDR_STAT, 1, 0, 32'h3);
    rd("split high", TCC_ADDR_T0HI, 8'hff);
    rd("second runs", TCC_ADDR_T1LO, 1, 3);
    wr(TCC_ADDR_CTRL, 8'h50);
    repeat (30) @(posedge pclk);
    rd("split high ovf", TCC_ADDR_STAT, 3, 0, 32'h3);
    wr(TCC_ADDR_MODE, 8'h31);
    wr(TCC_ADDR_T1LO, 8'h55);
    repeat (40) @(posedge pclk);
    rd("frozen", TCC_ADDR_T1LO, 8'h55);
    $display("test split done");
    wr(TCC_ADDR_MASK, 8'h0c);
    wr(TCC_ADDR_STAT, 8'h0f);
    wr(TCC_ADDR_T2HI, 8'hff);
    wr(TCC_ADDR_T2LO, 8'hff);
    wr(TCC_ADDR_T2CTL, 8'h0f);
    fall(2, 4);
    rd("t2 overflow", TCC_ADDR_STAT, 4, 0, 32'hc, 0, 2'b11);
    fall(3, 1);
    rd("trigger flag", TCC_ADDR_STAT, 8'h0c, 0, 32'hc);
    wr(TCC_ADDR_CAPLO, 8'haa);
    rd("capture low", TCC_ADDR_CAPLO, 8'h03);
    rd("capture high", TCC_ADDR_CAPHI, 8'h00);
    $display("test capture done");
    do_reset();
    rd("mode after reset", TCC_ADDR_MODE, 8'h00);
    rd("speed after reset", TCC_ADDR_SPEED, 8'h00);
    $display("test second reset done");
    end_of_test();
  end

endmodule

`default_nettype wire
